// File: design/ocd_cfg.svh
// Register offsets, field positions and reset values of the output channel block
`ifndef OCD_CFG_SVH
`define OCD_CFG_SVH

`define OCD_ADDR_W 8
`define OCD_OFS_OUT3_KIND 8'h3F
`define OCD_OFS_G23_TOP 8'h40
`define OCD_OFS_G23_MID 8'h41
`define OCD_OFS_G23_BOT 8'h42
`define OCD_OFS_OUT4_KIND 8'h43
`define OCD_OFS_OUT5_KIND 8'h44
`define OCD_OFS_G45_TOP 8'h45
`define OCD_OFS_G45_MID 8'h46
`define OCD_OFS_G45_BOT 8'h47
`define OCD_OFS_OUT6_KIND 8'h48
`define OCD_OFS_C6_TOP 8'h49
`define OCD_OFS_C6_MID 8'h4A
`define OCD_OFS_C6_BOT 8'h4B
`define OCD_OFS_OUT7_KIND 8'h4C
`define OCD_OFS_C7_SEL 8'h4D
`define OCD_OFS_C7_PRE_HI 8'h4E
`define OCD_OFS_C7_PRE_LO 8'h4F
`define OCD_OFS_C7_MID 8'h50
`define OCD_OFS_C7_BOT 8'h51
`define OCD_OFS_SYNC_BANK 8'h52
`define OCD_OFS_CHAN_CTRL 8'h60
`define OCD_OFS_CHAN_STAT 8'h61
// Field positions
`define OCD_KIND_MSB 5
`define OCD_SEL_MSB 6
`define OCD_SEL_LSB 4
`define OCD_TOPDIV_MSB 3
`define OCD_C7SEL_MSB 2
`define OCD_PREHI_MSB 6
`define OCD_PRELO_LSB 4
// Driver type codes
`define OCD_KIND_OFF 6'h00
`define OCD_KIND_LVDS 6'h10
`define OCD_KIND_CML 6'h14
`define OCD_KIND_PECL 6'h18
`define OCD_KIND_HCSL_LO 6'h2C
`define OCD_KIND_HCSL_HI 6'h2D
`define OCD_KIND_CMOS_LO 6'h30
// Divider special codes
`define OCD_DIV_OFF 20'h00000
`define OCD_DIV_BYPASS 20'h00001
`define OCD_DIV_MAX 20'hFFFFF
`define OCD_PRE_MIN 11'h000
`define OCD_PRE_MAX 11'h7FF
// Reset values
`define OCD_RST_BYTE 8'h00
`define OCD_RESERVED_RD 1'b0
`endif

// File: design/ocd_pkg.sv
// Types shared by the output channel divider and mux block
package ocd_pkg;
	typedef enum logic [1:0] {
		OCD_RUN,
		OCD_LATCHED
	} ocd_div_state_type;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ocd_bus_req_type;
	typedef struct packed {
		logic synth_a_postdiv_one;
		logic synth_a_postdiv_two;
		logic synth_b_postdiv_one;
		logic synth_b_postdiv_two;
	} ocd_sources_type;
endpackage

// File: design/ocd_output_channels.sv
// Output channels 3 to 7: driver kinds, source muxes and clock dividers
`timescale 1ns/10ps
`include "ocd_cfg.svh"

module ocd_output_channels #(
	parameter int DIV_W = 20,
	parameter int PRE_W = 11
) (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_SRST,
	// Register port
	input wire ocd_pkg::ocd_bus_req_type I_BUS,
	output logic [7:0] O_RDATA,
	// Post-divider clocks of the two synthesisers, already synchronous to I_CLK
	input wire ocd_pkg::ocd_sources_type I_SRC,
	// Channel outputs: group 2/3, group 4/5, channel 6, channel 7
	output logic [3:0] O_CLK,
	// Driver kinds of outputs 3 to 7, and a flag per output for a defined kind
	output logic [29:0] O_KIND,
	output logic [4:0] O_KIND_VALID,
	// Sync bank enables passed on unchanged
	output logic [7:0] O_SYNC_BANK
);

	// ************************************************************
	// Functions
	// ************************************************************
	function automatic logic pick_src(input logic [2:0] sel, input ocd_pkg::ocd_sources_type s);
		logic r;
		r = 1'b0;
		unique case (sel)
			3'h0: r = s.synth_a_postdiv_one;
			3'h1: r = s.synth_a_postdiv_two;
			3'h2: r = s.synth_b_postdiv_one;
			3'h3: r = s.synth_b_postdiv_two;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic kind_ok(input logic [5:0] k);
		return (k == `OCD_KIND_OFF) || (k == `OCD_KIND_LVDS) || (k == `OCD_KIND_CML) ||
			(k == `OCD_KIND_PECL) || (k == `OCD_KIND_HCSL_LO) ||
			(k == `OCD_KIND_HCSL_HI) || (k >= `OCD_KIND_CMOS_LO);
	endfunction

	function automatic logic div_sticky(input logic [DIV_W-1:0] v);
		return (v == `OCD_DIV_OFF) || (v == `OCD_DIV_BYPASS) || (v == `OCD_DIV_MAX);
	endfunction

	// ************************************************************
	// Register file
	// ************************************************************
	logic [5:0] kind [5];
	logic [2:0] sel [4];
	logic [7:0] top [4];
	logic [7:0] mid [4];
	logic [7:0] bot [4];
	logic [6:0] pre_hi;
	logic [7:0] sync_bank;
	logic [3:0] chan_rst;
	logic [3:0] power_down_cycle;
	logic wr;
	logic [7:0] a;
	logic [7:0] d;
	assign wr = I_BUS.wr;
	assign a = I_BUS.addr;
	assign d = I_BUS.wdata;

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			for (int i = 0; i < 5; i++) kind[i] <= 6'h00;
			for (int i = 0; i < 4; i++) begin
				sel[i] <= 3'h0;
				top[i] <= `OCD_RST_BYTE;
				mid[i] <= `OCD_RST_BYTE;
				bot[i] <= `OCD_RST_BYTE;
			end
			pre_hi <= 7'h00;
			sync_bank <= `OCD_RST_BYTE;
			chan_rst <= 4'h0;
			power_down_cycle <= 4'h0;
		end else begin
			chan_rst <= 4'h0;
			if (wr) begin
				unique case (a)
					`OCD_OFS_OUT3_KIND: kind[0] <= d[`OCD_KIND_MSB:0];
					`OCD_OFS_OUT4_KIND: kind[1] <= d[`OCD_KIND_MSB:0];
					`OCD_OFS_OUT5_KIND: kind[2] <= d[`OCD_KIND_MSB:0];
					`OCD_OFS_OUT6_KIND: kind[3] <= d[`OCD_KIND_MSB:0];
					`OCD_OFS_OUT7_KIND: kind[4] <= d[`OCD_KIND_MSB:0];
					`OCD_OFS_G23_TOP: begin
						sel[0] <= d[`OCD_SEL_MSB:`OCD_SEL_LSB];
						top[0] <= {4'h0, d[`OCD_TOPDIV_MSB:0]};
					end
					`OCD_OFS_G23_MID: mid[0] <= d;
					`OCD_OFS_G23_BOT: bot[0] <= d;
					`OCD_OFS_G45_TOP: begin
						sel[1] <= d[`OCD_SEL_MSB:`OCD_SEL_LSB];
						top[1] <= {4'h0, d[`OCD_TOPDIV_MSB:0]};
					end
					`OCD_OFS_G45_MID: mid[1] <= d;
					`OCD_OFS_G45_BOT: bot[1] <= d;
					`OCD_OFS_C6_TOP: begin
						sel[2] <= d[`OCD_SEL_MSB:`OCD_SEL_LSB];
						top[2] <= {4'h0, d[`OCD_TOPDIV_MSB:0]};
					end
					`OCD_OFS_C6_MID: mid[2] <= d;
					`OCD_OFS_C6_BOT: bot[2] <= d;
					`OCD_OFS_C7_SEL: sel[3] <= d[`OCD_C7SEL_MSB:0];
					`OCD_OFS_C7_PRE_HI: pre_hi <= d[`OCD_PREHI_MSB:0];
					`OCD_OFS_C7_PRE_LO: top[3] <= d;
					`OCD_OFS_C7_MID: mid[3] <= d;
					`OCD_OFS_C7_BOT: bot[3] <= d;
					`OCD_OFS_SYNC_BANK: sync_bank <= d;
					`OCD_OFS_CHAN_CTRL: begin
						chan_rst <= d[3:0];
						power_down_cycle <= d[7:4];
					end
					default: ;
				endcase
			end
		end
	end

	// ************************************************************
	// Divide values as written, and as taken by the dividers
	// ************************************************************
	logic [DIV_W-1:0] wr_val [4];
	logic [PRE_W-1:0] pre_wr;
	assign wr_val[0] = {top[0][3:0], mid[0], bot[0]};
	assign wr_val[1] = {top[1][3:0], mid[1], bot[1]};
	assign wr_val[2] = {top[2][3:0], mid[2], bot[2]};
	assign wr_val[3] = {top[3][3:0], mid[3], bot[3]};
	assign pre_wr = {pre_hi, top[3][7:`OCD_PRELO_LSB]};

	// Live values: a special setting freezes until a channel reset or power-down.
	// The freeze is kept per channel so other channels stay reprogrammable.
	// Bytes are taken one at a time, with no staging: a value that passes
	// through a special code while its bytes are written will freeze there,
	// so software writes all bytes and then pulses the channel reset.
	logic [DIV_W-1:0] live [4];
	logic [PRE_W-1:0] pre_live;
	ocd_pkg::ocd_div_state_type st [4];
	logic [3:0] hold;
	for (genvar g = 0; g < 4; g++) begin : g_live
		assign hold[g] = chan_rst[g] | power_down_cycle[g];
		always_ff @(posedge I_CLK) begin
			if (I_SRST) begin
				live[g] <= `OCD_DIV_OFF;
				st[g] <= ocd_pkg::OCD_RUN;
			end else if (hold[g] || st[g] == ocd_pkg::OCD_RUN) begin
				live[g] <= wr_val[g];
				st[g] <= div_sticky(wr_val[g]) ? ocd_pkg::OCD_LATCHED : ocd_pkg::OCD_RUN;
			end
		end
	end
	logic pre_st;
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			pre_live <= `OCD_PRE_MIN;
			pre_st <= 1'b0;
		end else if (hold[3] || !pre_st) begin
			pre_live <= pre_wr;
			pre_st <= (pre_wr == `OCD_PRE_MIN) || (pre_wr == `OCD_PRE_MAX);
		end
	end

	// ************************************************************
	// Source muxes and edge detection
	// ************************************************************
	logic [3:0] src;
	logic [3:0] src_q;
	logic [3:0] src_rise;
	assign src[0] = pick_src(sel[0], I_SRC);
	assign src[1] = pick_src(sel[1], I_SRC);
	assign src[2] = pick_src(sel[2], I_SRC);
	assign src[3] = pick_src(sel[3], I_SRC);
	assign src_rise = src & ~src_q;

	// Channel 7 prediv: ratio value+1, its output ticks clock the final divider
	logic [PRE_W-1:0] pre_cnt;
	logic pre_tick;
	assign pre_tick = src_rise[3] && (pre_cnt == pre_live);

	// Prediv output as a clock of its own, roughly half high.
	// Needed when the final divider is in bypass: then the whole channel ratio
	// is the prediv ratio alone, and the final stage has no count to shape it.
	logic pre_out;
	logic [PRE_W-1:0] pre_half;
	assign pre_half = (pre_live >> 1) + PRE_W'(1);

	// ************************************************************
	// Final dividers
	// ************************************************************
	logic [DIV_W-1:0] cnt [4];
	logic [3:0] tick;
	logic [3:0] div_out;
	assign tick = {pre_tick, src_rise[2:0]};
	for (genvar g = 0; g < 4; g++) begin : g_div
		// Bypass passes the source through; output set at the wrap and cleared at half count keeps the edge rate at
		// the input rate divided by the value, counting input rising edges.
		logic [DIV_W-1:0] half;
		assign half = live[g] >> 1;
		always_ff @(posedge I_CLK) begin
			if (I_SRST || hold[g] || live[g] == `OCD_DIV_OFF) begin
				cnt[g] <= '0;
				div_out[g] <= 1'b0;
			end else if (tick[g]) begin
				if (cnt[g] == live[g] - DIV_W'(1)) begin
					cnt[g] <= '0;
					div_out[g] <= 1'b1;
				end else begin
					cnt[g] <= cnt[g] + DIV_W'(1);
					if (cnt[g] + DIV_W'(1) == half)
						div_out[g] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST || hold[3]) begin
			pre_cnt <= '0;
			pre_out <= 1'b0;
		end else if (src_rise[3]) begin
			pre_cnt <= pre_tick ? '0 : pre_cnt + PRE_W'(1);
			// High from the tick for half the prediv span, low for the rest
			if (pre_tick)
				pre_out <= 1'b1;
			else if (pre_cnt + PRE_W'(1) == pre_half)
				pre_out <= 1'b0;
		end
	end

	// ************************************************************
	// Notes on the output stage
	// ************************************************************
	// A divided output lags the selected source by two clock cycles: one for
	// the divider flop and one for the output flop. A bypassed output lags
	// by one cycle only, except channel 7 when its prediv is not in bypass, so switching a channel between bypass and divide
	// shifts its phase; software is expected to reset the channel anyway.
	// Channel 7 in final bypass follows the prediv output when the prediv is
	// not itself in bypass, so the cascade ratio is kept in every setting.
	// Edges are counted on the block clock, so a source must stay at least
	// one clock cycle high and one low to be seen at all.

	// ************************************************************
	// Outputs and read-back
	// ************************************************************
	// Read data stand for exactly the cycle after the read strobe and are
	// zero otherwise, so a bus that ORs several slaves needs no extra gating.
	// Reserved bits read as zero whatever was written into them.
	// The status byte shows which channels run and which final dividers are frozen in a
	// special setting; frozen channels ignore new values until reset.
	logic [7:0] rd_mux;
	logic [3:0] active;
	for (genvar g = 0; g < 4; g++) begin : g_act
		assign active[g] = !power_down_cycle[g] && live[g] != `OCD_DIV_OFF;
	end
	always_comb begin
		rd_mux = 8'h00;
		unique case (a)
			`OCD_OFS_OUT3_KIND: rd_mux = {2'b00, kind[0]};
			`OCD_OFS_OUT4_KIND: rd_mux = {2'b00, kind[1]};
			`OCD_OFS_OUT5_KIND: rd_mux = {2'b00, kind[2]};
			`OCD_OFS_OUT6_KIND: rd_mux = {2'b00, kind[3]};
			`OCD_OFS_OUT7_KIND: rd_mux = {2'b00, kind[4]};
			`OCD_OFS_G23_TOP: rd_mux = {`OCD_RESERVED_RD, sel[0], top[0][3:0]};
			`OCD_OFS_G23_MID: rd_mux = mid[0];
			`OCD_OFS_G23_BOT: rd_mux = bot[0];
			`OCD_OFS_G45_TOP: rd_mux = {`OCD_RESERVED_RD, sel[1], top[1][3:0]};
			`OCD_OFS_G45_MID: rd_mux = mid[1];
			`OCD_OFS_G45_BOT: rd_mux = bot[1];
			`OCD_OFS_C6_TOP: rd_mux = {`OCD_RESERVED_RD, sel[2], top[2][3:0]};
			`OCD_OFS_C6_MID: rd_mux = mid[2];
			`OCD_OFS_C6_BOT: rd_mux = bot[2];
			`OCD_OFS_C7_SEL: rd_mux = {5'h00, sel[3]};
			`OCD_OFS_C7_PRE_HI: rd_mux = {`OCD_RESERVED_RD, pre_hi};
			`OCD_OFS_C7_PRE_LO: rd_mux = top[3];
			`OCD_OFS_C7_MID: rd_mux = mid[3];
			`OCD_OFS_C7_BOT: rd_mux = bot[3];
			`OCD_OFS_SYNC_BANK: rd_mux = sync_bank;
			`OCD_OFS_CHAN_CTRL: rd_mux = {power_down_cycle, 4'h0};
			`OCD_OFS_CHAN_STAT: rd_mux = {{st[3] == ocd_pkg::OCD_LATCHED,
				st[2] == ocd_pkg::OCD_LATCHED, st[1] == ocd_pkg::OCD_LATCHED,
				st[0] == ocd_pkg::OCD_LATCHED}, active};
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			src_q <= 4'h0;
			O_RDATA <= 8'h00;
			O_CLK <= 4'h0;
			O_KIND <= '0;
			O_KIND_VALID <= 5'h00;
			O_SYNC_BANK <= 8'h00;
		end else begin
			src_q <= src;
			O_RDATA <= I_BUS.rd ? rd_mux : 8'h00;
			for (int i = 0; i < 4; i++)
				O_CLK[i] <= (live[i] == `OCD_DIV_BYPASS)
					? ((i == 3 && pre_live != 0) ? pre_out : (src[i] & ~hold[i]))
					: div_out[i];
			for (int i = 0; i < 5; i++) begin
				O_KIND[i*6 +: 6] <= kind[i];
				O_KIND_VALID[i] <= kind_ok(kind[i]);
			end
			O_SYNC_BANK <= sync_bank;
		end
	end

endmodule // ocd_output_channels

// File: tb/ocd_monitor.sv
// Port checker of the output channel block
`timescale 1ns/10ps
module ocd_monitor #(
	parameter int DIV_W = 20,
	parameter int PRE_W = 11
) (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_SRST,
	// Watched ports
	input wire ocd_pkg::ocd_bus_req_type I_BUS,
	input wire logic [7:0] O_RDATA,
	input wire ocd_pkg::ocd_sources_type I_SRC,
	input wire logic [3:0] O_CLK,
	input wire logic [29:0] O_KIND,
	input wire logic [4:0] O_KIND_VALID,
	input wire logic [7:0] O_SYNC_BANK
);
	logic [7:0] sync_sh;
	logic [7:0] kind_sh;
	wire wr_sync = I_BUS.wr && I_BUS.addr == 8'h52;
	wire wr_kind = I_BUS.wr && I_BUS.addr == 8'h3F;
	// Shadows of the last written bytes, so the checks need no read
	always_ff @(posedge I_CLK) begin
		sync_sh <= I_SRST ? 8'h00 : (wr_sync ? I_BUS.wdata : sync_sh);
		kind_sh <= I_SRST ? 8'h00 : (wr_kind ? I_BUS.wdata : kind_sh);
	end
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SRST);
	sequence s_rd(a);
		I_BUS.rd && I_BUS.addr == a;
	endsequence
	property p_rdata_idle; !I_BUS.rd |=> O_RDATA == 8'h00; endproperty
	property p_sync_follow; wr_sync |-> ##2 O_SYNC_BANK == sync_sh; endproperty
	property p_sync_read; s_rd(8'h52) |=> O_RDATA == sync_sh; endproperty
	property p_kind_follow; wr_kind |-> ##3 O_KIND[5:0] == kind_sh[5:0]; endproperty
	property p_kind_resv; s_rd(8'h3F) |=> O_RDATA[7:6] == 2'b00; endproperty
	property p_sel_resv; s_rd(8'h4D) |=> O_RDATA[7:3] == 5'h00; endproperty
	property p_top_resv; s_rd(8'h40) |=> !O_RDATA[7]; endproperty
	property p_unmapped; s_rd(8'h30) |=> O_RDATA == 8'h00; endproperty
	property p_reset_quiet; $fell(I_SRST) |-> O_CLK == 4'h0 && O_KIND == 30'h0; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	a_sync_follow: assert property (p_sync_follow) else $error("sync bank not passed on");
	a_sync_read: assert property (p_sync_read) else $error("sync bank read wrong");
	a_kind_follow: assert property (p_kind_follow) else $error("kind out3 wrong");
	a_kind_resv: assert property (p_kind_resv) else $error("kind spare bits set");
	a_sel_resv: assert property (p_sel_resv) else $error("select spare bits set");
	a_top_resv: assert property (p_top_resv) else $error("top spare bit set");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs live at reset");
endmodule // ocd_monitor

bind ocd_output_channels ocd_monitor #(.DIV_W(DIV_W), .PRE_W(PRE_W)) u_mon (
	.I_CLK(I_CLK), .I_SRST(I_SRST), .I_BUS(I_BUS), .O_RDATA(O_RDATA), .I_SRC(I_SRC),
	.O_CLK(O_CLK), .O_KIND(O_KIND), .O_KIND_VALID(O_KIND_VALID), .O_SYNC_BANK(O_SYNC_BANK));

// File: tb/ocd_testbench.sv
// Self-checking bench of the output channel block
`timescale 1ns/10ps
module testbench;
	logic I_CLK;
	logic I_SRST;
	ocd_pkg::ocd_bus_req_type bus;
	ocd_pkg::ocd_sources_type src;
	logic [7:0] rdata;
	logic [3:0] oclk;
	logic [29:0] kind;
	logic [4:0] kvalid;
	logic [7:0] sync;
	int failures = 0;
	int check_count = 0;
	int cyc = 0;
	int n;
	logic [7:0] offs [5] = '{8'h3F, 8'h43, 8'h44, 8'h48, 8'h4C};
	logic [7:0] tops [3] = '{8'h40, 8'h45, 8'h49};
	ocd_output_channels dut (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_BUS(bus), .O_RDATA(rdata),
		.I_SRC(src), .O_CLK(oclk), .O_KIND(kind), .O_KIND_VALID(kvalid), .O_SYNC_BANK(sync));
	initial begin
		I_CLK = 1'b0;
		forever #5 I_CLK = ~I_CLK;
	end
	// Source periods 2, 4, 6 and 8 cycles, one per select code
	always @(posedge I_CLK) begin
		cyc <= cyc + 1;
		src <= {cyc % 2 < 1, cyc % 4 < 2, cyc % 6 < 3, cyc % 8 < 4};
		if (cyc > 30000) begin
			failures++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// Edge counts may land one off, as the window is not aligned to the output
	task automatic chkn(input int got, input int exp);
		chk(32'((got >= exp - 1 && got <= exp + 1) ? exp : got), 32'(exp));
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge I_CLK);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge I_CLK);
		bus <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge I_CLK);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge I_CLK);
		bus <= '0;
		@(negedge I_CLK);
		chk({24'h0, rdata}, {24'h0, exp});
	endtask
	task automatic meas(input int ch, input int w, input int exp);
		logic p;
		n = 0;
		repeat (20) @(negedge I_CLK);
		p = oclk[ch];
		repeat (w) begin
			@(negedge I_CLK);
			if (oclk[ch] === 1'b1 && p === 1'b0) n++;
			p = oclk[ch];
		end
		chkn(n, exp);
	endtask
	initial begin
		I_SRST = 1'b1;
		bus = '0;
		src = '0;
		repeat (6) @(posedge I_CLK);
		I_SRST <= 1'b0;
		wr(8'h30, 8'hFF);
		for (int i = 8'h3F; i <= 8'h52; i++) rd(8'(i), 8'h00);
		rd(8'h30, 8'h00);
		$display("test reset done");
		foreach (offs[i]) wr(offs[i], 8'hFF);
		foreach (offs[i]) rd(offs[i], 8'h3F);
		repeat (4) @(negedge I_CLK);
		chk({2'b00, kind}, {5{6'h3F}});
		chk({27'h0, kvalid}, 32'h1F);
		wr(8'h3F, 8'h01);
		wr(8'h43, 8'h10);
		wr(8'h52, 8'hA5);
		rd(8'h52, 8'hA5);
		repeat (4) @(negedge I_CLK);
		chk({20'h0, kind[11:0]}, 32'h401);
		chk({27'h0, kvalid}, 32'h1E);
		chk({24'h0, sync}, 32'hA5);
		$display("test kinds done");
		for (int c = 0; c < 3; c++) for (int s = 0; s < 4; s++) begin
			wr(tops[c], {1'b0, 3'(s), 4'h0});
			wr(tops[c] + 8'h2, 8'h02);
			wr(8'h60, 8'(1 << c));
			meas(c, 240, 240 / ((s + 1) * 4));
		end
		$display("test muxes done");
		wr(8'h42, 8'h01);
		wr(8'h60, 8'h01);
		meas(0, 240, 30);
		wr(8'h42, 8'h03);
		meas(0, 240, 30);
		rd(8'h42, 8'h03);
		wr(8'h60, 8'h01);
		meas(0, 240, 10);
		wr(8'h60, 8'h10);
		meas(0, 240, 0);
		wr(8'h42, 8'h00);
		wr(8'h60, 8'h00);
		meas(0, 240, 0);
		wr(8'h45, 8'h00);
		wr(8'h46, 8'h01);
		wr(8'h47, 8'h00);
		wr(8'h60, 8'h02);
		meas(1, 2048, 4);
		$display("test special codes done");
		for (int s = 0; s < 4; s++) begin
			wr(8'h4D, 8'(s));
			wr(8'h4F, 8'h10);
			wr(8'h51, 8'h03);
			wr(8'h60, 8'h08);
			meas(3, 480, 480 / ((s + 1) * 12));
		end
		wr(8'h4D, 8'h00);
		wr(8'h4E, 8'h01);
		wr(8'h4F, 8'h20);
		wr(8'h60, 8'h08);
		meas(3, 1140, 10);
		wr(8'h4E, 8'h00);
		wr(8'h4F, 8'h10);
		wr(8'h50, 8'h00);
		wr(8'h51, 8'h01);
		wr(8'h60, 8'h08);
		meas(3, 480, 120);
		$display("test cascade done");
		test_done();
	end
endmodule // testbench
